// *** selftest_pkg.sv ***
// Constants for the self-test status reporter
// Behaviour
// - Lamps off before test, on after pass
// - Green lamp blinks while controller operative
// - Green lamp steady after any failure
// - Signal completion to start initialization
// - Pass pattern brief on online, then activity
// - After failure never answer bus selection
// - Burn-in loop reruns self-test until failure
// - Eight-bit test-code port, bits 7 to 0
// - Each step shows its code at start
// - Failing step code stays on port
// - Reset codes 00, 01, 02, 04
// - Processor and memory codes 40 to 46
// - Peripheral codes 80, 81, 83, 84, 85
// - Steps run in order, stop at failure
package selftest_pkg;
  localparam int unsigned CODE_W     = 8;
  localparam int unsigned STEP_COUNT = 16;
  localparam int unsigned STEP_W     = 4;
  localparam int unsigned CLK_HZ     = 25_000_000;
  // Blink half period and pass display time in ms
  localparam int unsigned BLINK_HALF_MS = 250;
  localparam int unsigned PASS_SHOW_MS  = 500;
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
  localparam int unsigned PASS_SHOW_CYC  = CLK_HZ / 1000 * PASS_SHOW_MS;
  localparam logic [STEP_W-1:0] STEP_LAST = 4'hf;
  localparam logic [STEP_W-1:0] STEP_ZERO = 4'h0;
  // Test code table, step order
  localparam logic [CODE_W-1:0] CODE_TABLE [STEP_COUNT] = '{
    8'h00, 8'h01, 8'h02, 8'h04,
    8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46,
    8'h80, 8'h81, 8'h83, 8'h84, 8'h85};
  localparam logic [CODE_W-1:0] CODE_IDLE = 8'h00;

  typedef enum logic [2:0] {
    ST_CLEAR, ST_RUN, ST_WAIT, ST_PASS_SHOW, ST_ONLINE, ST_FAILED
  } phase_e;
endpackage : selftest_pkg

// *** code_rom.sv ***
// Registered lookup of the test code for each self-test step
`timescale 1ns/1ns
`default_nettype none
module code_rom (
  input  wire logic                              sys_clk_i,
  input  wire logic                              rst_n_i,
  input  wire logic [selftest_pkg::STEP_W-1:0]   step_i,
  output logic      [selftest_pkg::CODE_W-1:0]   code_o
);
  logic [selftest_pkg::CODE_W-1:0] next_code;

  // Table lookup
  always_comb begin
    next_code = selftest_pkg::CODE_TABLE[step_i];
  end

  // Read data from a register
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      code_o <= selftest_pkg::CODE_IDLE;
    end else begin
      code_o <= next_code;
    end
  end
endmodule : code_rom
`default_nettype wire

// *** selftest_status_reporter.sv ***
// Self-test sequencer driving status lamps and burn-in code port
`timescale 1ns/1ns
`default_nettype none
module selftest_status_reporter #(
  parameter int unsigned BLINK_HALF_CYC = selftest_pkg::BLINK_HALF_CYC,
  parameter int unsigned PASS_SHOW_CYC  = selftest_pkg::PASS_SHOW_CYC
) (
  input  wire logic                            sys_clk_i,
  input  wire logic                            rst_n_i,
  input  wire logic                            burn_in_select_strap_n_i,
  input  wire logic                            continuous_loop_strap_n_i,
  input  wire logic                            step_done_i,
  input  wire logic                            step_fail_i,
  input  wire logic                            online_ready_i,
  output logic                                 step_start_o,
  output logic [selftest_pkg::STEP_W-1:0]      step_index_o,
  output logic                                 selftest_done_o,
  output logic                                 selection_enable_o,
  output logic                                 green_activity_lamp_o,
  output logic                                 red_status_lamp_o,
  output logic [selftest_pkg::CODE_W-1:0]      test_code_n_o
);
  // Refuse timer settings the counters cannot serve
  if (BLINK_HALF_CYC < 1) begin : g_blink_chk
    $error("Blink half period must be at least one cycle");
  end

  if (PASS_SHOW_CYC < 1) begin : g_show_chk
    $error("Pass display time must be at least one cycle");
  end

  // Step index must reach every entry of the code table
  if (selftest_pkg::STEP_COUNT
      > (32'h1 << selftest_pkg::STEP_W)) begin : g_step_chk
    $error("Step index too narrow for the step table");
  end

  // Sequencer stops on the last table entry, not past it
  if (selftest_pkg::STEP_LAST
      != selftest_pkg::STEP_COUNT - 1) begin : g_last_chk
    $error("Last step does not match the step table");
  end

  // Shared end-of-count test; both timers count 0 to limit-1
  function automatic logic count_at_end(input logic [31:0] cnt,
                                        input int unsigned limit);
    count_at_end = (cnt == limit - 32'h1);
  endfunction : count_at_end

  selftest_pkg::phase_e              phase;
  selftest_pkg::phase_e              next_phase;
  logic [selftest_pkg::STEP_W-1:0]   step;
  logic [selftest_pkg::STEP_W-1:0]   next_step;
  logic [31:0]                       blink_cnt;
  logic [31:0]                       next_blink_cnt;
  logic                              blink_tick;
  logic [31:0]                       show_cnt;
  logic [31:0]                       next_show_cnt;
  logic                              blink;
  logic                              next_blink;
  logic                              next_start;
  logic                              next_done;
  logic                              next_sel;
  logic                              next_green;
  logic                              next_red;
  logic [selftest_pkg::CODE_W-1:0]   rom_code;
  logic [selftest_pkg::CODE_W-1:0]   next_code_n;
  logic                              loop_mode;
  logic                              last_step;

  // Continuous rerun needs both straps grounded
  assign loop_mode = !burn_in_select_strap_n_i
                     && !continuous_loop_strap_n_i;

  // Final entry of the code table reached
  assign last_step = (step == selftest_pkg::STEP_LAST);

  code_rom u_code_rom (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .step_i    (step),
    .code_o    (rom_code)
  );

  // Blink divider; one-cycle tick every half period
  // Free-running, so lamp phase is unrelated to the steps
  always_comb begin
    blink_tick     = count_at_end(blink_cnt, BLINK_HALF_CYC);
    next_blink_cnt = blink_tick ? 32'h0 : blink_cnt + 32'h1;
    next_blink     = blink_tick ? !blink : blink;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blink_cnt <= 32'h0;
      blink     <= 1'b0;
    end else begin
      blink_cnt <= next_blink_cnt;
      blink     <= next_blink;
    end
  end

  // Sequencer: one step at a time, halt at first failure
  // Straps are looked at only when the last step passes,
  // so a strap moved mid-pass takes effect at the pass end
  always_comb begin
    next_phase    = phase;
    next_step     = step;
    next_show_cnt = show_cnt;
    next_start    = 1'b0;
    case (phase)
      selftest_pkg::ST_CLEAR: begin
        // One dark cycle before the first step starts
        next_phase = selftest_pkg::ST_RUN;
        next_step  = selftest_pkg::STEP_ZERO;
      end
      selftest_pkg::ST_RUN: begin
        next_start = 1'b1;
        next_phase = selftest_pkg::ST_WAIT;
      end
      selftest_pkg::ST_WAIT: begin
        if (step_fail_i) begin
          next_phase = selftest_pkg::ST_FAILED;
        end else if (step_done_i) begin
          if (!last_step) begin
            next_step  = step + 4'h1;
            next_phase = selftest_pkg::ST_RUN;
          end else if (loop_mode) begin
            next_step  = selftest_pkg::STEP_ZERO;
            next_phase = selftest_pkg::ST_RUN;
          end else begin
            next_phase = selftest_pkg::ST_PASS_SHOW;
          end
        end
      end
      selftest_pkg::ST_PASS_SHOW: begin
        // Count only once firmware reports online
        // Count is never cleared here: only reset comes back
        if (online_ready_i) begin
          if (count_at_end(show_cnt, PASS_SHOW_CYC)) begin
            next_phase = selftest_pkg::ST_ONLINE;
          end else begin
            next_show_cnt = show_cnt + 32'h1;
          end
        end
      end
      default: begin
        next_phase = phase; // Online and failed are terminal
      end
    endcase
  end

  // Output decode; all outputs registered
  // Decoded from the current phase, so every lamp and
  // status change lags the phase by one clock
  always_comb begin
    next_done   = (phase == selftest_pkg::ST_PASS_SHOW)
                  || (phase == selftest_pkg::ST_ONLINE);
    next_sel    = (phase == selftest_pkg::ST_ONLINE);
    next_green  = 1'b0;
    next_red    = 1'b0;
    // Failure keeps last shown code: port is not updated
    next_code_n = test_code_n_o;
    case (phase)
      selftest_pkg::ST_CLEAR: begin
        next_green = 1'b0;
        next_red   = 1'b0;
      end
      selftest_pkg::ST_RUN, selftest_pkg::ST_WAIT: begin
        next_green  = blink;
        next_code_n = ~rom_code;
      end
      selftest_pkg::ST_PASS_SHOW: begin
        next_green = 1'b1;
        next_red   = 1'b1;
      end
      selftest_pkg::ST_ONLINE: begin
        // Red falls dark by default, green back to activity
        next_green = blink;
      end
      selftest_pkg::ST_FAILED: begin
        // Lamps and code freeze; only a reset leaves
        next_green = 1'b1;
      end
      default: begin
        next_green = 1'b0;
      end
    endcase
  end

  // State and output registers
  // Outputs come straight from these flops, so the
  // fixture never sees decode glitches
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase                 <= selftest_pkg::ST_CLEAR;
      step                  <= selftest_pkg::STEP_ZERO;
      show_cnt              <= 32'h0;
      step_start_o          <= 1'b0;
      step_index_o          <= selftest_pkg::STEP_ZERO;
      selftest_done_o       <= 1'b0;
      selection_enable_o    <= 1'b0;
      green_activity_lamp_o <= 1'b0;
      red_status_lamp_o     <= 1'b0;
      test_code_n_o         <= ~selftest_pkg::CODE_IDLE;
    end else begin
      phase                 <= next_phase;
      step                  <= next_step;
      show_cnt              <= next_show_cnt;
      step_start_o          <= next_start;
      step_index_o          <= step;
      selftest_done_o       <= next_done;
      selection_enable_o    <= next_sel;
      green_activity_lamp_o <= next_green;
      red_status_lamp_o     <= next_red;
      test_code_n_o         <= next_code_n;
    end
  end
endmodule : selftest_status_reporter
`default_nettype wire

// *** selftest_asserts.sv ***
// Port checks for the self-test status reporter
`timescale 1ns/1ns
`default_nettype none
module selftest_asserts #(
  parameter int unsigned BLINK_HALF_CYC = 4,
  parameter int unsigned PASS_SHOW_CYC  = 8
) (
  input wire logic       sys_clk_i,
  input wire logic       rst_n_i,
  input wire logic       step_done_i,
  input wire logic       step_fail_i,
  input wire logic       online_ready_i,
  input wire logic       step_start_o,
  input wire logic [3:0] step_index_o,
  input wire logic       selftest_done_o,
  input wire logic       selection_enable_o,
  input wire logic       green_activity_lamp_o,
  input wire logic       red_status_lamp_o,
  input wire logic [7:0] test_code_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // A passed step that is not the last one
  sequence step_passed;
    step_done_i && !step_fail_i && step_index_o != 4'hf;
  endsequence
  // Frozen state after a failure
  sequence fail_frozen;
    (green_activity_lamp_o && !step_start_o && !selection_enable_o
      && $stable(test_code_n_o)) [*8];
  endsequence
  start_pulse_a:
    assert property (step_start_o |=> !step_start_o) else $error("long start");
  code_show_a:
    assert property (step_start_o |=> test_code_n_o ==
      ~selftest_pkg::CODE_TABLE[$past(step_index_o)]) else $error("bad code");
  next_step_a:
    assert property (step_passed |-> ##[2:3] step_start_o)
    else $error("next step missing");
  fail_hold_a:
    assert property (step_fail_i |-> ##2 fail_frozen) else $error("not held");
  clear_lamps_a:
    assert property (!$past(rst_n_i) |->
      (!green_activity_lamp_o && !red_status_lamp_o) [*2])
    else $error("lamps not clear");
  pass_lamps_a:
    assert property ($rose(selftest_done_o) |->
      green_activity_lamp_o && red_status_lamp_o) else $error("no pass lamps");
  sel_gate_a:
    assert property (selection_enable_o |-> online_ready_i &&
      !red_status_lamp_o) else $error("selection too early");
  pass_brief_a:
    assert property ($rose(online_ready_i) && selftest_done_o |->
      !selection_enable_o [*7] ##[1:4] selection_enable_o)
    else $error("pass show length");
  blink_on_a:
    assert property (selection_enable_o && $changed(green_activity_lamp_o)
      |-> ##[1:5] $changed(green_activity_lamp_o)) else $error("no blink");
endmodule : selftest_asserts
bind selftest_status_reporter selftest_asserts #(
  .BLINK_HALF_CYC(BLINK_HALF_CYC), .PASS_SHOW_CYC(PASS_SHOW_CYC)) chk_i (
  .sys_clk_i, .rst_n_i, .step_done_i, .step_fail_i, .online_ready_i,
  .step_start_o, .step_index_o, .selftest_done_o, .selection_enable_o,
  .green_activity_lamp_o, .red_status_lamp_o, .test_code_n_o);
`default_nettype wire

// *** burn_in_fixture.sv ***
// Burn-in fixture model answering each self-test step
`timescale 1ns/1ns
`default_nettype none
module burn_in_fixture (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       start_i,
  input  wire logic [3:0] idx_i,
  input  wire logic       burn_in_i,
  input  wire logic [3:0] fail_idx_i,
  input  wire logic [1:0] fail_pass_i,
  output logic            done_o,
  output logic            fail_o,
  output logic            sel_strap_n_o,
  output logic            loop_strap_n_o
);
  logic [2:0] wait_cnt;
  logic [1:0] pass_no;
  logic       busy;
  // Both straps grounded only in burn-in
  assign sel_strap_n_o  = !burn_in_i;
  assign loop_strap_n_o = !burn_in_i;
  // Odd steps answer slowly, even ones promptly
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {busy, done_o, fail_o, wait_cnt, pass_no} <= '0;
    end else begin
      done_o <= 1'b0;
      fail_o <= 1'b0;
      if (start_i) begin
        busy <= 1'b1;
        wait_cnt <= {idx_i[0], 2'h1};
        pass_no <= pass_no + 2'(idx_i == 4'h0);
      end else if (busy && wait_cnt != 3'h0) begin
        wait_cnt <= wait_cnt - 3'h1;
      end else if (busy) begin
        busy <= 1'b0;
        fail_o <= idx_i == fail_idx_i && pass_no == fail_pass_i;
        done_o <= !(idx_i == fail_idx_i && pass_no == fail_pass_i);
      end
    end
  end
endmodule : burn_in_fixture
`default_nettype wire

// *** testbench.sv ***
// Self-checking bench for the self-test status reporter
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk, rst_n, online, burn, done, fail, sel_n, loop_n, prev;
  logic start, sdone, sel_en, green, red;
  logic [3:0] idx, f_idx;
  logic [1:0] f_pass;
  logic [7:0] code_n;
  int bad_count, n_checks, n, flips;
  logic [7:0] codes [16] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h40, 8'h41,
    8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h80, 8'h81, 8'h83, 8'h84, 8'h85};
  selftest_status_reporter #(.BLINK_HALF_CYC(4), .PASS_SHOW_CYC(8))
    selftest_status_reporter_i (.sys_clk_i(clk), .rst_n_i(rst_n),
    .burn_in_select_strap_n_i(sel_n), .continuous_loop_strap_n_i(loop_n),
    .step_done_i(done), .step_fail_i(fail), .online_ready_i(online),
    .step_start_o(start), .step_index_o(idx), .selftest_done_o(sdone),
    .selection_enable_o(sel_en), .green_activity_lamp_o(green),
    .red_status_lamp_o(red), .test_code_n_o(code_n));
  burn_in_fixture burn_in_fixture_i (.clk_i(clk), .rst_n_i(rst_n),
    .start_i(start), .idx_i(idx), .burn_in_i(burn), .fail_idx_i(f_idx),
    .fail_pass_i(f_pass), .done_o(done), .fail_o(fail),
    .sel_strap_n_o(sel_n), .loop_strap_n_o(loop_n));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // Straps settle before reset lifts, as the fixture needs
  task automatic restart(input logic b, input logic [3:0] fi,
                         input logic [1:0] fp);
    @(posedge clk);
    {rst_n, online, burn, f_idx, f_pass} <= {2'b00, b, fi, fp};
    repeat (20) @(posedge clk);
    check(code_n, 8'hff);
    rst_n <= 1'b1;
  endtask : restart
  // Waits for a step start, reads its index and code
  task automatic step_wait(input logic [3:0] i);
    n = 0;
    do @(negedge clk); while (start !== 1'b1 && ++n < 200);
    check({3'h0, start, idx}, {4'h1, i});
    @(negedge clk);
    check(code_n, ~codes[i]);
  endtask : step_wait
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Cut a hang short far beyond the expected run
  initial begin
    #400000;
    bad_count++;
    print_verdict();
  end
  initial begin
    {rst_n, online, burn, f_idx, f_pass} = '0;
    restart(1'b0, 4'h0, 2'h0);
    for (int i = 0; i < 16; i++) step_wait(4'(i));
    n = 0;
    do @(negedge clk); while (sdone !== 1'b1 && ++n < 100);
    check({4'h0, sdone, sel_en, green, red}, 8'h0b);
    @(posedge clk) online <= 1'b1;
    n = 0;
    do @(negedge clk); while (sel_en !== 1'b1 && ++n < 100);
    check({6'h0, sel_en, red}, 8'h02);
    flips = 0;
    repeat (40) begin
      prev = green;
      @(negedge clk);
      flips += int'(green !== prev);
    end
    check(8'(flips), 8'h0a);
    $display("test power_up_pass finished");
    // Failure on the sixth step, online asked for anyway
    restart(1'b0, 4'h5, 2'h1);
    for (int i = 0; i < 6; i++) step_wait(4'(i));
    @(posedge clk) online <= 1'b1;
    repeat (60) @(negedge clk);
    check(code_n, ~8'h41);
    check({3'h0, green, red, sel_en, sdone, start}, 8'h10);
    $display("test step_failure finished");
    // Burn-in loop fails on the second pass at code 83
    restart(1'b1, 4'hd, 2'h2);
    for (int i = 0; i < 30; i++) step_wait(4'(i % 16));
    repeat (60) @(negedge clk);
    check(code_n, ~8'h83);
    check({7'h0, sdone}, 8'h00);
    $display("test burn_in_loop finished");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
